/* File: core/pssr_decoder.sv */
// Per-channel stop, silence insertion and repeat command decoder with APB status.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Overview of operation
// [R1] First byte upper nibble 0110 stops every channel whose mask bit is set.
// [R2] A stopped channel shows accept high and active-low busy high.
// [R3] Stop is taken during playback whatever the accept level.
// [R4] Host waits busy_low_time_3 and sees busy high before next command.
// [R5] Host repeats the stop if busy does not return high.
// [R6] An all-zero channel mask makes any of the four commands ignored.
// [R7] Host always sets at least one mask bit.
// [R8] Upper nibble 0111 is silence insertion; second byte is the length field.
// [R9] Host issues silence only while the channel accepts commands.
// [R10] Silence lasts (length plus one) times 4 ms.
// [R11] Host programs the length field to 04h or more.
// [R12] A silence segment is never looped by repeat.
// [R13] Upper nibble 1000 sets looping on every masked channel whose accept is high.
// [R14] Host issues repeat-on only while the channel accepts commands.
// [R15] Looping continues until repeat-off or stop.
// [R16] An edited phrase loops as the whole sequence.
// [R17] Upper nibble 1001 clears looping on every masked channel.
// [R18] Repeat-off is taken at any accept level.
// [R19] Releasing repeat drives the channel's accept high.
// [R20] Commands split by first-byte upper nibble; only silence takes a second byte.
// ----------------------------------------------------------------------
module pssr_decoder
    import pssr_pkg::*;
#(
    parameter int SIL_UNIT_CYC = SILENCE_UNIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Command bytes from the command port
    input wire logic cmd_valid_in,
    input wire pssr_cmd_t cmd_in,
    // Playback engine events
    input wire logic [CHANNELS-1:0] play_start_in,
    input wire logic [CHANNELS-1:0] phrase_end_in,
    // Channel status and engine controls
    output logic [CHANNELS-1:0] chan_cmd_accept_out,
    output logic [CHANNELS-1:0] chan_active_low_out,
    output logic [CHANNELS-1:0] repeat_out,
    output logic [CHANNELS-1:0] halt_out,
    output logic [CHANNELS-1:0] replay_out,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);

    localparam int SUB_W = (SIL_UNIT_CYC > 1) ? $clog2(SIL_UNIT_CYC) : 1;
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SIL_UNIT_CYC - 1);

    // ------------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------------
    pssr_dec_t dec_q, dec_d;
    logic [3:0] sil_mask_q, sil_mask_d;
    logic [3:0] stop_m, rep_on_m, rep_off_m, sil_m;
    logic [7:0] sil_len;
    // Clearing the enable bit makes the decoder drop every command byte.
    logic ctrl_en_q, ctrl_en_d;

    // A first byte always restarts decoding, so a lost length byte never
    // shifts the meaning of the bytes that follow it.
    always_comb begin
        dec_d = dec_q;
        sil_mask_d = sil_mask_q;
        stop_m = 4'h0;
        rep_on_m = 4'h0;
        rep_off_m = 4'h0;
        sil_m = 4'h0;
        sil_len = cmd_in.data;
        if (cmd_valid_in && ctrl_en_q) begin
            if (cmd_in.first) begin
                dec_d = DEC_OPCODE;
                if (mask_of(cmd_in.data) != 4'h0) begin // [R6]
                    case (opcode_of(cmd_in.data)) // [R20]
                        OP_STOP: stop_m = mask_of(cmd_in.data); // [R1] [R3]
                        OP_REPEAT_SET: rep_on_m = mask_of(cmd_in.data); // [R13]
                        OP_REPEAT_CLEAR: rep_off_m = mask_of(cmd_in.data); // [R17]
                        OP_SILENCE: begin
                            dec_d = DEC_LENGTH; // [R8]
                            sil_mask_d = mask_of(cmd_in.data);
                        end
                        default: ;
                    endcase
                end
            end else if (dec_q == DEC_LENGTH) begin
                sil_m = sil_mask_q; // [R8]
                dec_d = DEC_OPCODE;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dec_q <= DEC_OPCODE;
            sil_mask_q <= 4'h0;
        end else begin
            dec_q <= dec_d;
            sil_mask_q <= sil_mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Channel state
    // ------------------------------------------------------------------
    // Each channel has its own unit divider so that a silence is exact to
    // the cycle instead of lagging a shared free-running tick.
    pssr_chst_t st_q [CHANNELS], st_d [CHANNELS];
    logic [SUB_W-1:0] sub_q [CHANNELS], sub_d [CHANNELS];
    logic [8:0] units_q [CHANNELS], units_d [CHANNELS];
    logic [7:0] len_q [CHANNELS], len_d [CHANNELS];
    logic [CHANNELS-1:0] pend_q, pend_d, rep_q, rep_d, acc_q, acc_d;
    logic [CHANNELS-1:0] busy_n_q, busy_n_d, halt_q, halt_d, replay_q, replay_d;
    logic [CHANNELS-1:0] silent;

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            st_d[i] = st_q[i];
            sub_d[i] = sub_q[i];
            units_d[i] = units_q[i];
            len_d[i] = len_q[i];
            pend_d[i] = pend_q[i];
            rep_d[i] = rep_q[i];
            halt_d[i] = 1'b0;
            replay_d[i] = 1'b0;
            case (st_q[i])
                CH_IDLE: begin
                    if (play_start_in[i]) begin
                        st_d[i] = CH_PLAY;
                    end else if (sil_m[i]) begin
                        st_d[i] = CH_SILENT;
                        sub_d[i] = '0;
                        units_d[i] = {1'b0, sil_len} + 9'h001; // [R10]
                        len_d[i] = sil_len;
                    end
                end
                CH_PLAY: begin
                    if (sil_m[i] && acc_q[i]) begin
                        pend_d[i] = 1'b1;
                        len_d[i] = sil_len;
                    end
                    // A silence taken in the cycle the phrase ends still starts at once.
                    // Testing the next value keeps it from lingering as a stale
                    // request that a later phrase would apply.
                    if (phrase_end_in[i]) begin
                        if (rep_q[i]) begin
                            replay_d[i] = 1'b1; // [R15] [R16]
                        end else if (pend_d[i]) begin
                            st_d[i] = CH_SILENT;
                            pend_d[i] = 1'b0;
                            sub_d[i] = '0;
                            units_d[i] = {1'b0, len_d[i]} + 9'h001; // [R10]
                        end else begin
                            st_d[i] = CH_IDLE;
                        end
                    end
                end
                CH_SILENT: begin
                    // No replay is raised here, so repeat never loops silence.
                    // The unit counter spends SIL_UNIT_CYC cycles on each length step.
                    if (sub_q[i] == SUB_LAST) begin
                        sub_d[i] = '0;
                        units_d[i] = units_q[i] - 9'h001;
                        if (units_q[i] == 9'h001) begin
                            st_d[i] = CH_IDLE; // [R12]
                        end
                    end else begin
                        sub_d[i] = sub_q[i] + SUB_W'(1);
                    end
                end
                default: st_d[i] = CH_IDLE;
            endcase
            if (rep_on_m[i] && acc_q[i] && st_q[i] != CH_SILENT) begin
                rep_d[i] = 1'b1; // [R13]
            end
            if (rep_off_m[i]) begin
                rep_d[i] = 1'b0; // [R17] [R18]
            end
            // Stop is applied last so that it wins over every other request.
            if (stop_m[i]) begin
                st_d[i] = CH_IDLE; // [R1] [R3]
                rep_d[i] = 1'b0; // [R15]
                pend_d[i] = 1'b0;
                replay_d[i] = 1'b0;
                halt_d[i] = 1'b1;
            end
            // Accept drops while a loop or a queued silence holds the channel.
            acc_d[i] = (st_d[i] == CH_IDLE) ||
                (st_d[i] == CH_PLAY && !rep_d[i] && !pend_d[i]); // [R2] [R19]
            busy_n_d[i] = (st_d[i] == CH_IDLE); // [R2]
            silent[i] = (st_q[i] == CH_SILENT);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < CHANNELS; i++) begin
                st_q[i] <= CH_IDLE;
                sub_q[i] <= '0;
                units_q[i] <= 9'h000;
                len_q[i] <= 8'h00;
            end
            pend_q <= '0;
            rep_q <= '0;
            acc_q <= '1;
            busy_n_q <= '1;
            halt_q <= '0;
            replay_q <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                st_q[i] <= st_d[i];
                sub_q[i] <= sub_d[i];
                units_q[i] <= units_d[i];
                len_q[i] <= len_d[i];
            end
            pend_q <= pend_d;
            rep_q <= rep_d;
            acc_q <= acc_d;
            busy_n_q <= busy_n_d;
            halt_q <= halt_d;
            replay_q <= replay_d;
        end
    end

    // Every output is a register, so the engine sees clean one-cycle pulses.
    assign chan_cmd_accept_out = acc_q;
    assign chan_active_low_out = busy_n_q;
    assign repeat_out = rep_q;
    assign halt_out = halt_q;
    assign replay_out = replay_q;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Pready is registered, so every access phase lasts exactly two cycles.
    // Read data and the error flag are held until the next access; the
    // master only looks at them while pready is high.
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic apb_first, apb_done, hit;

    always_comb begin
        apb_first = psel_in && penable_in && !pready_q;
        apb_done = psel_in && penable_in && pready_q;
        pready_d = apb_first;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        ctrl_en_d = ctrl_en_q;
        hit = (paddr_in == REG_CTRL) || (paddr_in == REG_STATUS) ||
            (paddr_in == REG_SILENCE_LEN);
        if (apb_first) begin
            pslverr_d = !hit;
            prdata_d = 32'h0000_0000;
            if (!pwrite_in) begin
                case (paddr_in)
                    REG_CTRL: prdata_d[CTRL_ENABLE_BIT] = ctrl_en_q;
                    REG_STATUS: begin
                        prdata_d[ST_ACCEPT_LSB +: CHANNELS] = acc_q;
                        prdata_d[ST_ACTIVE_LOW_LSB +: CHANNELS] = busy_n_q;
                        prdata_d[ST_REPEAT_LSB +: CHANNELS] = rep_q;
                        prdata_d[ST_SILENT_LSB +: CHANNELS] = silent;
                    end
                    REG_SILENCE_LEN: prdata_d = {len_q[3], len_q[2], len_q[1], len_q[0]};
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
        // A write lands only at the edge where the access phase completes.
        if (apb_done && pwrite_in && paddr_in == REG_CTRL) begin
            ctrl_en_d = pwdata_in[CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            ctrl_en_q <= CTRL_ENABLE_RST;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            ctrl_en_q <= ctrl_en_d;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;

endmodule // pssr_decoder

/* File: pkg/pssr_pkg.sv */
// Package of constants, types and helpers for the playback stop/silence/repeat decoder.
package pssr_pkg;

    // ------------------------------------------------------------------
    // Channels and command opcodes
    // ------------------------------------------------------------------
    localparam int CHANNELS = 4;
    localparam logic [3:0] OP_STOP = 4'h6;
    localparam logic [3:0] OP_SILENCE = 4'h7;
    localparam logic [3:0] OP_REPEAT_SET = 4'h8;
    localparam logic [3:0] OP_REPEAT_CLEAR = 4'h9;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SILENCE_UNIT_MS = 4;
    localparam int SILENCE_UNIT_CYC = (CLK_HZ / 1000) * SILENCE_UNIT_MS;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_SILENCE_LEN = 12'h008;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam int ST_ACCEPT_LSB = 0;
    localparam int ST_ACTIVE_LOW_LSB = 4;
    localparam int ST_REPEAT_LSB = 8;
    localparam int ST_SILENT_LSB = 12;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } pssr_cmd_t;

    typedef enum {DEC_OPCODE, DEC_LENGTH} pssr_dec_t;
    typedef enum {CH_IDLE, CH_PLAY, CH_SILENT} pssr_chst_t;

    function automatic logic [3:0] opcode_of(input logic [7:0] b);
        return b[7:4];
    endfunction

    function automatic logic [3:0] mask_of(input logic [7:0] b);
        return b[3:0];
    endfunction

endpackage

/* File: tb/pssr_decoder_asserts.sv */
// Checker of the decoder's command relations at its ports.
`timescale 1ns/100ps
module pssr_decoder_asserts
    import pssr_pkg::*;
#(
    parameter int SIL_UNIT_CYC = SILENCE_UNIT_CYC
) (
    input logic clk_in,
    input logic rst_n_in,
    input logic cmd_valid_in,
    input pssr_cmd_t cmd_in,
    input logic [CHANNELS-1:0] play_start_in,
    input logic [CHANNELS-1:0] phrase_end_in,
    input logic [CHANNELS-1:0] chan_cmd_accept_out,
    input logic [CHANNELS-1:0] chan_active_low_out,
    input logic [CHANNELS-1:0] repeat_out,
    input logic [CHANNELS-1:0] halt_out,
    input logic [CHANNELS-1:0] replay_out,
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic [11:0] paddr_in,
    input logic [31:0] pwdata_in,
    input logic [31:0] prdata_out,
    input logic pready_out,
    input logic pslverr_out
);
    // The enable bit is tracked from completed writes, so dropped bytes are excused.
    logic en_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_q <= CTRL_ENABLE_RST;
        end else if (psel_in && penable_in && pready_out && pwrite_in &&
            paddr_in == REG_CTRL) begin
            en_q <= pwdata_in[CTRL_ENABLE_BIT];
        end
    end
    wire logic hd = cmd_valid_in && cmd_in.first && en_q;
    wire logic [3:0] op = cmd_in.data[7:4];
    wire logic [3:0] m = cmd_in.data[3:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_stop_halt; hd && op == OP_STOP |=> halt_out == $past(m); endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("stop halt");
    property p_stop_lvl;
        hd && op == OP_STOP |=> &(chan_cmd_accept_out & chan_active_low_out | ~$past(m));
    endproperty
    a_stop_lvl: assert property (p_stop_lvl) else $error("stop levels");
    property p_zero; hd && m == 4'h0 |=> halt_out == 4'h0 && $stable(repeat_out); endproperty
    a_zero: assert property (p_zero) else $error("zero mask");
    property p_rset; hd && op == OP_REPEAT_SET |=> &(repeat_out | ~$past(m & chan_cmd_accept_out));
    endproperty
    a_rset: assert property (p_rset) else $error("repeat on");
    property p_rclr;
        hd && op == OP_REPEAT_CLEAR |=> !(|(repeat_out & $past(m)))
            && &(chan_cmd_accept_out | ~$past(m & repeat_out));
    endproperty
    a_rclr: assert property (p_rclr) else $error("repeat off");
    property p_replay; |replay_out |-> !(|(replay_out & ~$past(repeat_out))); endproperty
    a_replay: assert property (p_replay) else $error("replay without loop");
    property p_fall;
        |($past(repeat_out) & ~repeat_out) |-> $past(hd && (op == OP_STOP || op == OP_REPEAT_CLEAR));
    endproperty
    a_fall: assert property (p_fall) else $error("loop dropped");
    property p_second; cmd_valid_in && !cmd_in.first |=> halt_out == 4'h0; endproperty
    a_second: assert property (p_second) else $error("second byte");
    c_stop: cover property (hd && op == OP_STOP && m != 4'h0);
    c_replay: cover property (|replay_out);
    c_silent: cover property ($fell(chan_active_low_out[1]));
endmodule // pssr_decoder_asserts

bind pssr_decoder pssr_decoder_asserts #(.SIL_UNIT_CYC(SIL_UNIT_CYC)) u_asserts (.*);

/* File: tb/pssr_decoder_tb.sv */
// Self-checking bench for the stop, silence and repeat command decoder.
`timescale 1ns/100ps
module pssr_decoder_tb;
    import pssr_pkg::*;
    // A short silence unit keeps the run brief; durations derive from it.
    localparam int UNIT = 10;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid_in;
    pssr_cmd_t cmd_in;
    logic [3:0] play_start_in = '0;
    logic [3:0] phrase_end_in = '0;
    logic [3:0] chan_cmd_accept_out;
    logic [3:0] chan_active_low_out;
    logic [3:0] repeat_out;
    logic [3:0] halt_out;
    logic [3:0] replay_out;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0;
    logic [31:0] prdata_out;
    logic [31:0] rd;
    logic pready_out;
    logic pslverr_out;
    logic err;
    int n_errors = 0;
    int check_count = 0;
    always #20 clk_in = ~clk_in;
    pssr_decoder #(.SIL_UNIT_CYC(UNIT)) u_dut (.*);
    pssr_host u_host (.clk_in(clk_in), .accept_in(chan_cmd_accept_out),
        .active_low_in(chan_active_low_out), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_in);
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        chk("apb wait", 0, 32'(n == 20));
    endtask
    task automatic ev(input logic [3:0] s, input logic [3:0] e);
        @(posedge clk_in);
        play_start_in <= s;
        phrase_end_in <= e;
        @(posedge clk_in);
        play_start_in <= '0;
        phrase_end_in <= '0;
        @(negedge clk_in);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, REG_STATUS, '0);
        chk("status", 32'h0000_00ff, rd);
        apb(1'b0, 12'h00c, '0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, REG_CTRL, 32'h1);
        ev(4'h5, 4'h0);
        chk("busy", 32'ha, 32'(chan_active_low_out));
        u_host.issue({OP_REPEAT_SET, 4'h0}, 8'h00, 1'b0);
        chk("zero mask", 0, 32'(repeat_out));
        u_host.issue({OP_REPEAT_SET, 4'h4}, 8'h00, 1'b1);
        chk("repeat", 32'h4, 32'(repeat_out));
        ev(4'h0, 4'h4);
        chk("replay", 32'h4, 32'(replay_out));
        u_host.issue({OP_REPEAT_CLEAR, 4'h4}, 8'h00, 1'b0);
        chk("repeat off", 0, 32'(repeat_out));
        chk("accept", 32'hf, 32'(chan_cmd_accept_out));
        u_host.issue({OP_REPEAT_SET, 4'h4}, 8'h00, 1'b1);
        u_host.stop(4'h5);
        chk("halt", 32'h5, 32'(halt_out));
        chk("stopped", 32'h0ff, {20'h0, repeat_out, chan_active_low_out, chan_cmd_accept_out});
        u_host.send(1'b0, {OP_STOP, 4'h2});
        u_host.rest();
        chk("lone byte", 0, 32'(halt_out));
        u_host.issue({OP_SILENCE, 4'h2}, 8'h04, 1'b1);
        chk("silent", 32'hd, 32'(chan_active_low_out));
        u_host.issue({OP_REPEAT_SET, 4'h2}, 8'h00, 1'b0);
        chk("no loop", 0, 32'(repeat_out));
        repeat (5 * UNIT - 3) @(negedge clk_in);
        chk("still silent", 32'hd, 32'(chan_active_low_out));
        repeat (1) @(negedge clk_in);
        chk("silence end", 32'hf, 32'(chan_active_low_out));
        apb(1'b0, REG_SILENCE_LEN, '0);
        chk("length", 32'h0000_0400, rd);
        ev(4'h8, 4'h0);
        u_host.issue({OP_SILENCE, 4'h8}, 8'h04, 1'b1);
        chk("queued", 32'h7, 32'(chan_cmd_accept_out));
        ev(4'h0, 4'h8);
        chk("queued silent", 32'h7, 32'(chan_active_low_out));
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, REG_CTRL, '0);
        chk("ctrl off", 0, rd);
        u_host.issue({OP_STOP, 4'h1}, 8'h00, 1'b0);
        chk("disabled", 0, 32'(halt_out));
        apb(1'b1, REG_CTRL, 32'h1);
        print_verdict();
    end
endmodule // pssr_decoder_tb

/* File: tb/pssr_host.sv */
// Host model that issues command bytes to the decoder.
`timescale 1ns/100ps
module pssr_host
    import pssr_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Channel status
    input wire logic [CHANNELS-1:0] accept_in,
    input wire logic [CHANNELS-1:0] active_low_in,
    // Command bytes
    output logic cmd_valid_out,
    output pssr_cmd_t cmd_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
    end
    task automatic send(input logic f, input logic [7:0] b);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_out <= '{first: f, data: b};
    endtask
    // Idle data toggles so that a stale byte never looks valid.
    task automatic rest();
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_out <= ~cmd_out;
        @(negedge clk_in);
    endtask
    task automatic issue(input logic [7:0] b, input logic [7:0] len, input bit obey);
        for (int i = 0; obey && i < 200 && (accept_in & b[3:0]) != b[3:0]; i++) begin
            @(negedge clk_in);
        end
        send(1'b1, b);
        if (b[7:4] == OP_SILENCE) begin
            send(1'b0, len);
        end
        rest();
    endtask
    task automatic stop(input logic [3:0] mask);
        send(1'b1, {OP_STOP, mask});
        rest();
        if ((active_low_in & mask) != mask) begin
            send(1'b1, {OP_STOP, mask});
            rest();
        end
    endtask
endmodule // pssr_host
